// file: verilog/hifr_core.sv
// Gate control, fault latching and auto-retry timing of the hot-insertion controller.
// Assumes comparator outputs and pins are asynchronous levels; host bit writes are
// one-cycle strobes from logic on mclk.
`timescale 1ns/1ps
`default_nettype none
module hifr_core
   import hifr_pkg::*;
#(
   parameter int unsigned TD_CYC     = TD_CYC_DEFAULT, // Start-up period in cycles
   parameter bit          OC_RETRY_V = 1'b0             // Variant: overcurrent retry default
)(
   input  wire logic mclk,                        // 20 MHz clock
   input  wire logic arst_n,                      // Async reset, active low
   input  wire logic on_pin,                      // On pin
   input  wire logic enable_n_pin,                // Enable-bar pin, active low
   input  wire logic low_supply_cmp,              // Undervoltage comparator, high = under
   input  wire logic high_supply_limit_input,     // Overvoltage comparator, high = over
   input  wire logic shunt_supply_lockout,        // Input supply lockout active
   input  wire logic internal_5v_rail_lockout,    // Internal rail lockout active
   input  wire logic limit_cmp,                   // Sense above current limit level
   input  wire logic fast_trip_cmp,               // Sense above fast trip level
   input  wire logic power_bad_event,             // Good check timer expired, good input high
   input  wire logic input_step,                  // Input step in progress
   input  wire logic wr_on_ctl_set,               // Host sets on-control bit
   input  wire logic wr_on_ctl_clr,               // Host clears on-control bit
   input  wire logic wr_en_chg_set,               // Host sets enable-change fault
   input  wire logic wr_en_chg_clr,               // Host clears enable-change fault
   input  wire logic wr_fault_clr,                // Host clears uv/ov/oc/pb faults
   input  wire logic wr_retry_we,                 // Host writes retry bits
   input  wire logic [3:0] wr_retry_val,          // {pb, oc, uv, ov} retry values
   output logic gate_on,                          // Gate drive command
   output logic fast_pull_down,                   // Immediate gate pull-down
   output logic timer_discharge,                  // Discharge soft-start and delay timer
   output logic good_reset,                       // Reset both power-good outputs
   output logic gate_on_status_bit,               // Gate status
   output logic enable_present_bit,               // Enable-bar level
   output logic enable_change_fault_bit,          // Enable-bar changed
   output logic transistor_on_control_bit,        // On-control bit
   output logic high_supply_present_bit,          // Overvoltage present
   output logic high_supply_fault_bit,            // Overvoltage fault
   output logic low_supply_fault_bit,             // Undervoltage fault
   output logic overcurrent_present_bit,          // Overcurrent present
   output logic overcurrent_fault_bit,            // Overcurrent fault
   output logic power_bad_fault_bit,              // Power-bad fault
   output logic high_supply_retry_bit,            // Overvoltage retry
   output logic low_supply_retry_bit,             // Undervoltage retry
   output logic overcurrent_retry_bit,            // Overcurrent retry
   output logic power_bad_retry_bit               // Power-bad retry
);
   localparam int NS = 8;
   // Three-stage synchroniser bank, one bit per pin
   logic [NS-1:0] raw;
   logic [NS-1:0] s1_ff, s2_ff, s3_ff;            // Stages
   logic [NS-1:0] q_ff;                           // Accepted level
   assign raw = {input_step, power_bad_event, fast_trip_cmp, limit_cmp, internal_5v_rail_lockout,
                 shunt_supply_lockout, high_supply_limit_input, low_supply_cmp};

   // Synchronise all external levels except the on and enable pins; accept once stages two and three agree
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff  <= '0;
      end
      else
      begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff  <= (s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff));
      end

   // Pins with edge meaning have own stages; reset assumes enable high, on low
   logic on_s1_ff, on_s2_ff, on_s3_ff, on_ff;
   logic en_s1_ff, en_s2_ff, en_s3_ff, en_ff;
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
      begin
         on_s1_ff <= 1'b0; on_s2_ff <= 1'b0; on_s3_ff <= 1'b0; on_ff <= 1'b0;
         en_s1_ff <= 1'b1; en_s2_ff <= 1'b1; en_s3_ff <= 1'b1; en_ff <= 1'b1;
      end
      else
      begin
         on_s1_ff <= on_pin;
         on_s2_ff <= on_s1_ff;
         on_s3_ff <= on_s2_ff;
         if (on_s2_ff == on_s3_ff)
            on_ff <= on_s3_ff;
         en_s1_ff <= enable_n_pin;
         en_s2_ff <= en_s1_ff;
         en_s3_ff <= en_s2_ff;
         if (en_s2_ff == en_s3_ff)
            en_ff <= en_s3_ff;
      end

   logic uv, ov, vin_lo, rail_lo, lim, fast, pbad, step;
   assign {step, pbad, fast, lim, rail_lo, vin_lo, ov, uv} = q_ff;

   // Edge detection on accepted levels and on the on-control bit
   logic on_d_ff, en_d_ff, ctl_d_ff;
   logic on_rise, on_fall, en_fall, en_edge, ctl_fall;
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
      begin
         on_d_ff  <= 1'b0;
         en_d_ff  <= 1'b1;
         ctl_d_ff <= 1'b0;
      end
      else
      begin
         on_d_ff  <= on_ff;
         en_d_ff  <= en_ff;
         ctl_d_ff <= transistor_on_control_bit;
      end
   assign on_rise  = on_ff & ~on_d_ff;
   assign on_fall  = ~on_ff & on_d_ff;
   assign en_fall  = ~en_ff & en_d_ff;
   assign en_edge  = en_ff ^ en_d_ff;
   assign ctl_fall = ~transistor_on_control_bit & ctl_d_ff;

   // Enable status follows the pin; the change flag is set on either edge
   assign enable_present_bit = en_ff;
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
         enable_change_fault_bit <= 1'b0;
      else if (rail_lo)
         enable_change_fault_bit <= 1'b0;
      else if (en_edge | wr_en_chg_set)
         enable_change_fault_bit <= 1'b1;
      else if (wr_en_chg_clr)
         enable_change_fault_bit <= 1'b0;

   // Delayed copy of on-high after enable falls; handles on tied high
   logic [2:0] enl_cnt_ff;
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
         enl_cnt_ff <= 3'h0;
      else if (en_fall)
         enl_cnt_ff <= 3'(EN_LATCH_CYC);
      else if (enl_cnt_ff != 3'h0)
         enl_cnt_ff <= enl_cnt_ff - 3'h1;
   logic en_copy;
   assign en_copy = (enl_cnt_ff == 3'h1) & on_ff;

   // On-control bit; edges first, host strobes after
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
         transistor_on_control_bit <= 1'b0;
      else if (rail_lo)
         transistor_on_control_bit <= 1'b0;
      else if (on_rise | en_copy)
         transistor_on_control_bit <= 1'b1;
      else if (on_fall)
         transistor_on_control_bit <= 1'b0;
      else if (wr_on_ctl_set)
         transistor_on_control_bit <= 1'b1;
      else if (wr_on_ctl_clr)
         transistor_on_control_bit <= 1'b0;

   // Retry bits; overcurrent default from variant
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
      begin
         high_supply_retry_bit <= RETRY_RST;
         low_supply_retry_bit  <= RETRY_RST;
         overcurrent_retry_bit <= OC_RETRY_V;
         power_bad_retry_bit   <= RETRY_RST;
      end
      else if (wr_retry_we)
         {power_bad_retry_bit, overcurrent_retry_bit, low_supply_retry_bit,
          high_supply_retry_bit} <= wr_retry_val;

   // Breaker timer: counts while limit comparator holds
   logic [$clog2(BREAKER_CYC+1)-1:0] brk_ff;
   logic oc_trip;
   assign oc_trip = lim & (brk_ff == ($bits(brk_ff))'(BREAKER_CYC - 1));
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
         brk_ff <= '0;
      else if (!lim | oc_trip)
         brk_ff <= '0;
      else
         brk_ff <= brk_ff + 1'b1;

   // Fault flags; set beats clear, on falling clears all
   logic fclr;
   assign fclr = on_fall | ctl_fall | rail_lo;
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
      begin
         high_supply_fault_bit <= 1'b0;
         low_supply_fault_bit  <= 1'b0;
         overcurrent_fault_bit <= 1'b0;
         power_bad_fault_bit   <= 1'b0;
      end
      else
      begin
         if (ov)
            high_supply_fault_bit <= 1'b1;
         else if (fclr | wr_fault_clr)
            high_supply_fault_bit <= 1'b0;
         if (uv)
            low_supply_fault_bit <= 1'b1;
         else if (fclr | wr_fault_clr)
            low_supply_fault_bit <= 1'b0;
         if (oc_trip)
            overcurrent_fault_bit <= 1'b1;
         else if (fclr | wr_fault_clr)
            overcurrent_fault_bit <= 1'b0;
         if (pbad)
            power_bad_fault_bit <= 1'b1;
         else if (fclr | wr_fault_clr)
            power_bad_fault_bit <= 1'b0;
      end

   assign high_supply_present_bit = ov;

   // Overcurrent present: set at trip, cleared once gate is off
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
         overcurrent_present_bit <= 1'b0;
      else if (oc_trip)
         overcurrent_present_bit <= 1'b1;
      else if (!gate_on)
         overcurrent_present_bit <= 1'b0;

   // Fault state machine
   typedef enum logic [4:0] {
      HIFR_RUN   = 5'b0_0001,                     // Free to drive gate
      HIFR_HOLD  = 5'b0_0010,                     // Faulted, waiting for clear
      HIFR_WAIT  = 5'b0_0100,                     // Retry delay counting
      HIFR_COOL  = 5'b0_1000,                     // Overcurrent cooling, uninterruptible
      HIFR_OVH   = 5'b1_0000                      // Overvoltage hold
   } hifr_state_t;
   typedef enum logic [1:0] {HIFR_K_UV, HIFR_K_OC, HIFR_K_PB} hifr_kind_t;
   hifr_state_t st_ff;
   hifr_kind_t  kind_ff;
   logic [31:0] dly_ff;                           // Retry delay counter, cycles

   function automatic logic [31:0] periods(input int unsigned n);
      periods = 32'(n * TD_CYC);
   endfunction : periods

   logic released;                                // Latched fault allowed to retry
   always_comb
   begin
      case (kind_ff)
         HIFR_K_UV: released = !uv & (low_supply_retry_bit | !low_supply_fault_bit);
         HIFR_K_OC: released = overcurrent_retry_bit | !overcurrent_fault_bit;
         default:   released = power_bad_retry_bit | !power_bad_fault_bit;
      endcase
   end

   // Fault sequencing; cooling is never interrupted
   always_ff @(posedge mclk or negedge arst_n)
      if (!arst_n)
      begin
         st_ff   <= HIFR_RUN;
         kind_ff <= HIFR_K_UV;
         dly_ff  <= 32'h0000_0000;
      end
      else
         case (st_ff)
            HIFR_RUN:
               if (oc_trip)
               begin
                  kind_ff <= HIFR_K_OC;
                  st_ff   <= HIFR_HOLD;
               end
               else if (pbad)
               begin
                  kind_ff <= HIFR_K_PB;
                  st_ff   <= HIFR_HOLD;
               end
               else if (uv)
               begin
                  kind_ff <= HIFR_K_UV;
                  st_ff   <= HIFR_HOLD;
               end
               else if (ov)
                  st_ff <= HIFR_OVH;
            HIFR_OVH:
               if (!ov & (high_supply_retry_bit | !high_supply_fault_bit))
                  st_ff <= HIFR_RUN;
            HIFR_HOLD:
               if (released & !pbad)
               begin
                  dly_ff <= (kind_ff == HIFR_K_OC) ? periods(OC_PERIODS) :
                            (kind_ff == HIFR_K_UV) ? periods(UV_PERIODS) : periods(PB_PERIODS);
                  st_ff  <= (kind_ff == HIFR_K_OC) ? HIFR_COOL : HIFR_WAIT;
               end
            HIFR_WAIT:
               if (uv | ov | pbad)
                  st_ff <= HIFR_RUN;               // Re-evaluate new fault
               else if (dly_ff <= 32'h0000_0001)
                  st_ff <= HIFR_RUN;
               else
                  dly_ff <= dly_ff - 32'h0000_0001;
            HIFR_COOL:
               if (dly_ff <= 32'h0000_0001)
                  st_ff <= HIFR_RUN;
               else
                  dly_ff <= dly_ff - 32'h0000_0001;
            default:
               st_ff <= HIFR_RUN;
         endcase

   // Off decision; input step does not enter it
   logic off_cond;
   assign off_cond = !on_ff | !transistor_on_control_bit | en_ff | uv | ov
                   | vin_lo | rail_lo | (st_ff != HIFR_RUN) | oc_trip | pbad;
   assign gate_on_status_bit = !off_cond;
   assign gate_on            = !off_cond & !fast;
   assign fast_pull_down     = fast;
   assign timer_discharge    = off_cond;
   // Good outputs reset on off decisions except in overvoltage or HIFR_OVH without trip, power-bad, undervoltage or HIFR_HOLD; fast trip alone does not reset them
   assign good_reset = off_cond & !(ov | st_ff == HIFR_OVH)
                     | (off_cond & (oc_trip | pbad | uv | st_ff == HIFR_HOLD));
   logic unused_step;
   assign unused_step = step;

   // Assertions
   chk_ov_gate_off: assert property (@(posedge mclk) disable iff (!arst_n)
      ov |-> !gate_on && timer_discharge)
      else $error("gate on during overvoltage");
   chk_ov_keeps_good: assert property (@(posedge mclk) disable iff (!arst_n)
      (ov && st_ff == HIFR_RUN && on_ff && transistor_on_control_bit && !en_ff && !uv && !vin_lo
       && !rail_lo && !lim && !pbad) |-> !good_reset)
      else $error("good reset by overvoltage");
   chk_trip_sets: assert property (@(posedge mclk) disable iff (!arst_n)
      oc_trip |=> overcurrent_fault_bit && overcurrent_present_bit && brk_ff == 0)
      else $error("breaker trip did not log");
   chk_breaker_len: assert property (@(posedge mclk) disable iff (!arst_n)
      $rose(lim) |-> !oc_trip [*8])
      else $error("breaker tripped early");
   chk_oc_present_clr: assert property (@(posedge mclk) disable iff (!arst_n)
      (overcurrent_present_bit && !gate_on && !oc_trip) |=> !overcurrent_present_bit)
      else $error("overcurrent present stuck");
   chk_en_change: assert property (@(posedge mclk) disable iff (!arst_n)
      (en_edge && !rail_lo) |=> enable_change_fault_bit)
      else $error("enable change missed");
   chk_on_rise: assert property (@(posedge mclk) disable iff (!arst_n)
      (on_rise && !rail_lo) |=> transistor_on_control_bit)
      else $error("on rise did not set control");
   chk_rail_clear: assert property (@(posedge mclk) disable iff (!arst_n)
      rail_lo |=> !transistor_on_control_bit && !enable_change_fault_bit)
      else $error("rail lockout did not clear");
   chk_cool_holds: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_ff == HIFR_COOL && dly_ff > 1) |=> st_ff == HIFR_COOL)
      else $error("cooling interrupted");
   chk_fast_trip: assert property (@(posedge mclk) disable iff (!arst_n)
      fast |-> !gate_on)
      else $error("gate on during fast trip");
   chk_latch_off: assert property (@(posedge mclk) disable iff (!arst_n)
      (st_ff == HIFR_HOLD && kind_ff == HIFR_K_OC && !overcurrent_retry_bit && overcurrent_fault_bit
       && !wr_retry_we && !wr_fault_clr && !fclr) |=> st_ff == HIFR_HOLD)
      else $error("latched fault released");
endmodule : hifr_core
`default_nettype wire

// file: verilog/hifr_pkg.sv
// Constants for the hot-insertion gate control and fault retry block.
// Assumes a single 20 MHz clock; comparator results arrive as digital levels.
package hifr_pkg;
   localparam int unsigned CLK_HZ          = 20_000_000;  // Clock rate
   localparam int unsigned BREAKER_US      = 530;         // Breaker time, microseconds
   // Longest time, rounded down
   localparam int unsigned BREAKER_CYC     = BREAKER_US * (CLK_HZ / 1_000_000);
   localparam int unsigned OC_PERIODS      = 4;           // Cooling in start-up periods
   localparam int unsigned UV_PERIODS      = 1;           // Undervoltage retry periods
   localparam int unsigned PB_PERIODS      = 1;           // Power-bad retry periods
   localparam int unsigned TD_CYC_DEFAULT  = 5_120_000;   // 256 ms start-up period
   localparam int unsigned EN_LATCH_CYC    = 4;           // On copy delay after enable fall
   localparam logic        RETRY_RST       = 1'b1;        // Reset of uv/ov/pb retry bits
endpackage : hifr_pkg

// file: test/hifr_far_side.sv
// Far-side model: pass transistor with a load short behind it.
// Assumes the current-limit comparator only sees current while the gate is driven.
`timescale 1ns/1ps
`default_nettype none
module hifr_far_side (
   input  wire logic gate_on,    // Gate drive command
   input  wire logic short_req,  // Bench asks for a load short
   output logic      limit_cmp   // Sense above limit level
);
   // No gate, no current: a short cannot trip a transistor that is off
   assign limit_cmp = gate_on & short_req;
endmodule : hifr_far_side
`default_nettype wire

// file: test/hot_insert_fault_retry_bench.sv
// Self-checking bench for hifr_core with a shortened start-up period.
// Assumes hifr_far_side closes the current loop; inputs change at negedge.
`timescale 1ns/1ps
`default_nettype none
module hot_insert_fault_retry_bench;
   import hifr_pkg::*;
   localparam int unsigned TD = 20;  // Short start-up period
   logic mclk, arst_n, on_pin, enable_n_pin, low_supply_cmp, high_supply_limit_input;
   logic shunt_supply_lockout, internal_5v_rail_lockout, fast_trip_cmp, power_bad_event;
   logic input_step, wr_on_ctl_set, wr_on_ctl_clr, wr_en_chg_set, wr_en_chg_clr;
   logic wr_fault_clr, wr_retry_we, short_req, limit_cmp;
   logic [3:0] wr_retry_val;  // Retry values
   logic gate_on, fast_pull_down, timer_discharge, good_reset, gate_on_status_bit;
   logic enable_present_bit, enable_change_fault_bit, transistor_on_control_bit;
   logic high_supply_present_bit, high_supply_fault_bit, low_supply_fault_bit;
   logic overcurrent_present_bit, overcurrent_fault_bit, power_bad_fault_bit;
   logic high_supply_retry_bit, low_supply_retry_bit, overcurrent_retry_bit, power_bad_retry_bit;
   int   err_count, samples_checked, n;  // Counters
   hifr_core #(.TD_CYC(TD), .OC_RETRY_V(1'b0)) DUT (.mclk, .arst_n, .on_pin, .enable_n_pin,
      .low_supply_cmp, .high_supply_limit_input, .shunt_supply_lockout, .internal_5v_rail_lockout,
      .limit_cmp, .fast_trip_cmp, .power_bad_event, .input_step, .wr_on_ctl_set, .wr_on_ctl_clr,
      .wr_en_chg_set, .wr_en_chg_clr, .wr_fault_clr, .wr_retry_we, .wr_retry_val, .gate_on,
      .fast_pull_down, .timer_discharge, .good_reset, .gate_on_status_bit, .enable_present_bit,
      .enable_change_fault_bit, .transistor_on_control_bit, .high_supply_present_bit,
      .high_supply_fault_bit, .low_supply_fault_bit, .overcurrent_present_bit,
      .overcurrent_fault_bit, .power_bad_fault_bit, .high_supply_retry_bit, .low_supply_retry_bit,
      .overcurrent_retry_bit, .power_bad_retry_bit);
   hifr_far_side far (.gate_on(gate_on), .short_req(short_req), .limit_cmp(limit_cmp));
   // Free-running 20 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // One comparison, mismatch printed at once
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Bounded wait for the gate to reach a level; n counts cycles
   task wait_gate(input logic v, input int lim);
      n = 0;
      while (gate_on !== v && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
   endtask : wait_gate
   // Let synchronisers settle
   task idle(input int c);
      repeat (c) @(negedge mclk);
   endtask : idle
   task t_reset;
      check({high_supply_retry_bit, low_supply_retry_bit, power_bad_retry_bit}, 3'h7);
      check(overcurrent_retry_bit, 1'b0);
      check(enable_present_bit, 1'b1);
      check(gate_on, 1'b0);
      $display("test reset done");
   endtask : t_reset
   task t_turn_on;
      on_pin = 1'b1;
      enable_n_pin = 1'b0;
      idle(8);
      check(transistor_on_control_bit, 1'b1);
      check(enable_change_fault_bit, 1'b1);
      check(enable_present_bit, 1'b0);
      wait_gate(1'b1, 4 * TD + 40);
      check({gate_on, gate_on_status_bit, timer_discharge}, 3'h6);
      $display("test turn_on done");
   endtask : t_turn_on
   task t_overvoltage;
      high_supply_limit_input = 1'b1;
      wait_gate(1'b0, 8);
      idle(1);
      check({high_supply_present_bit, high_supply_fault_bit}, 2'h3);
      check(good_reset, 1'b0);
      high_supply_limit_input = 1'b0;
      wait_gate(1'b1, 8);
      check(gate_on, 1'b1);
      $display("test overvoltage done");
   endtask : t_overvoltage
   task t_overcurrent;
      short_req = 1'b1;
      wait_gate(1'b0, BREAKER_CYC + 20);
      check(n >= BREAKER_CYC, 1'b1);
      check(good_reset, 1'b1);
      idle(3);
      check({overcurrent_fault_bit, overcurrent_present_bit}, 2'h2);
      short_req = 1'b0;
      high_supply_limit_input = 1'b1;
      idle(6 * TD);
      check(gate_on, 1'b0);
      high_supply_limit_input = 1'b0;
      wr_fault_clr = 1'b1;
      @(negedge mclk);
      wr_fault_clr = 1'b0;
      wait_gate(1'b1, 4 * TD + 20);
      check(n >= 4 * TD - 1, 1'b1);
      check(gate_on, 1'b1);
      $display("test overcurrent done");
   endtask : t_overcurrent
   // Fast trip, input step, undervoltage and power-bad retry with default retry bits
   task t_fast_uv_pb;
      fast_trip_cmp = 1'b1;
      idle(5);
      check({fast_pull_down, gate_on, gate_on_status_bit}, 3'h5);
      fast_trip_cmp = 1'b0;
      input_step = 1'b1;
      idle(6);
      check({fast_pull_down, gate_on, good_reset, timer_discharge}, 4'h4);
      input_step = 1'b0;
      low_supply_cmp = 1'b1;
      idle(6);
      check({gate_on, low_supply_fault_bit, good_reset}, 3'h3);
      low_supply_cmp = 1'b0;
      wait_gate(1'b1, 2 * TD + 20);
      check(n >= TD && n <= TD + 10, 1'b1);
      check(gate_on, 1'b1);
      power_bad_event = 1'b1;
      idle(6);
      check({gate_on, power_bad_fault_bit, good_reset}, 3'h3);
      power_bad_event = 1'b0;
      wait_gate(1'b1, 2 * TD + 20);
      check(n >= TD && n <= TD + 10, 1'b1);
      check({gate_on, power_bad_fault_bit}, 2'h3);
      $display("test fast_uv_pb done");
   endtask : t_fast_uv_pb
   task t_latch_and_off;
      wr_retry_we = 1'b1;
      wr_retry_val = 4'h0;
      @(negedge mclk);
      wr_retry_we = 1'b0;
      high_supply_limit_input = 1'b1;
      idle(8);
      high_supply_limit_input = 1'b0;
      idle(2 * TD);
      check(gate_on, 1'b0);
      on_pin = 1'b0;
      idle(8);
      check({transistor_on_control_bit, high_supply_fault_bit}, 2'h0);
      check({timer_discharge, good_reset}, 2'h3);
      $display("test latch_and_off done");
   endtask : t_latch_and_off
   task t_lockout;
      on_pin = 1'b1;
      idle(8);
      wr_on_ctl_clr = 1'b1;
      wr_en_chg_clr = 1'b1;
      @(negedge mclk);
      wr_on_ctl_clr = 1'b0;
      wr_en_chg_clr = 1'b0;
      @(negedge mclk);
      check({transistor_on_control_bit, enable_change_fault_bit}, 2'h0);
      enable_n_pin = 1'b1;
      idle(8);
      enable_n_pin = 1'b0;
      idle(6);
      check(transistor_on_control_bit, 1'b0);
      idle(4);
      check({transistor_on_control_bit, enable_change_fault_bit}, 2'h3);
      wr_on_ctl_clr = 1'b1;
      @(negedge mclk);
      wr_on_ctl_clr = 1'b0;
      wr_on_ctl_set = 1'b1;
      @(negedge mclk);
      wr_on_ctl_set = 1'b0;
      @(negedge mclk);
      check(transistor_on_control_bit, 1'b1);
      internal_5v_rail_lockout = 1'b1;
      idle(8);
      wr_en_chg_set = 1'b1;
      @(negedge mclk);
      wr_en_chg_set = 1'b0;
      @(negedge mclk);
      check({transistor_on_control_bit, enable_change_fault_bit, gate_on}, 3'h0);
      $display("test lockout done");
   endtask : t_lockout
   // Verdict and end of run
   task print_verdict;
      $display("checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   // Watchdog well beyond breaker plus retry times
   initial
   begin
      #(40000 * 50);
      err_count++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      {arst_n, on_pin, low_supply_cmp, high_supply_limit_input, shunt_supply_lockout} = '0;
      {internal_5v_rail_lockout, fast_trip_cmp, power_bad_event, input_step, short_req} = '0;
      {wr_on_ctl_set, wr_on_ctl_clr, wr_en_chg_set, wr_en_chg_clr, wr_fault_clr, wr_retry_we} = '0;
      wr_retry_val = 4'h0;
      enable_n_pin = 1'b1;
      err_count = 0;
      samples_checked = 0;
      idle(6);
      arst_n = 1'b1;
      idle(6);
      t_reset();
      t_turn_on();
      t_overvoltage();
      t_overcurrent();
      t_fast_uv_pb();
      t_latch_and_off();
      t_lockout();
      print_verdict();
   end
endmodule : hot_insert_fault_retry_bench
`default_nettype wire
